// file: design/eth_trigger_handshake.sv
// layered trigger sequencer with external trigger in and completion pulse out
// How it works
// - a trigger is the falling edge of the filtered input line
// - only layers whose source is external react to the trigger
// - completion waits for settling time plus programmed delay
// - every measurement ends with one completion pulse for all measure sources
// - scan bypass with external source pulses on each scan return
// - arm bypass with external source pulses on each arm return
// - triggered reading is taken, stored the next cycle, completion sent settle plus delay plus one cycles after the reading
// - reset: arm and scan immediate, arm count 1, scan infinite, no bypass, continuous
// - immediate arm and scan drop straight to wait in measure layer
// - bypass skips the event only on the first pass into a layer
// - arm and scan counts 1 to 99999, zero means infinite
// - hold arm source keeps the sequence out of the scan layer
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module eth_trigger_handshake
  import eth_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trig_in_n,
  output logic done_out_n,
  output logic meas_start,
  output logic store_strobe,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  eth_trig_if trig();
  eth_trig_filter u_filt (.aclk(aclk), .aresetn(aresetn), .trig_in_n(trig_in_n), .out(trig));

  // configuration, sequencer and status registers
  logic [15:0] ctrl_r;
  logic [16:0] arm_cnt_r;
  logic [16:0] scan_cnt_r;
  logic [15:0] settle_r;
  logic [15:0] delay_r;
  logic [7:0] pulse_r;
  logic [15:0] timer_r;
  eth_state_t st_r;
  eth_state_t st_nxt;
  logic [16:0] arm_done_r;
  logic [16:0] scan_done_r;
  logic arm_first_r;
  logic scan_first_r;
  logic [16:0] wait_r;
  logic [15:0] tick_r;
  logic manual_r;
  logic init_r;
  logic ret_pulse_r;
  logic done_n_r;
  logic meas_r;
  logic store_r;
  logic [31:0] readings_r;

  wire eth_src_t arm_src = eth_src_t'(ctrl_r[ETH_F_ARM_SRC +: 3]);
  wire eth_src_t scan_src = eth_src_t'(ctrl_r[ETH_F_SCAN_SRC +: 3]);
  wire eth_src_t meas_src = eth_src_t'(ctrl_r[ETH_F_MEAS_SRC +: 3]);
  wire logic arm_byp = ctrl_r[ETH_F_ARM_BYP];
  wire logic scan_byp = ctrl_r[ETH_F_SCAN_BYP];
  wire logic cont_on = ctrl_r[ETH_F_CONT];
  wire logic tick = tick_r == timer_r;

  function automatic logic src_event(input eth_src_t s, input logic fall, input logic man,
                                     input logic tk);
    unique case (s)
      ETH_SRC_IMM: src_event = 1'b1;
      ETH_SRC_EXT: src_event = fall | man;
      ETH_SRC_MAN: src_event = man;
      ETH_SRC_TIM: src_event = tk;
      default: src_event = 1'b0;
    endcase
  endfunction

  function automatic logic cnt_more(input logic [16:0] lim, input logic [16:0] done);
    cnt_more = (lim == ETH_CNT_INF) || (17'(done + 17'h0_0001) < lim);
  endfunction

  wire logic arm_go = src_event(arm_src, trig.fall, manual_r, tick) ||
    (arm_byp && arm_first_r && arm_src != ETH_SRC_HOLD);
  wire logic scan_go = src_event(scan_src, trig.fall, manual_r, tick) ||
    (scan_byp && scan_first_r);
  wire logic meas_go = src_event(meas_src, trig.fall, manual_r, tick);
  wire logic wait_end = wait_r == 17'({1'b0, settle_r} + {1'b0, delay_r});
  wire logic pulse_end = wait_r == 17'({9'h000, pulse_r} - 17'h0_0001);
  wire logic scan_more = cnt_more(scan_cnt_r, scan_done_r);
  wire logic arm_more = cnt_more(arm_cnt_r, arm_done_r);
  wire logic scan_ret = scan_byp && scan_src == ETH_SRC_EXT && st_r == ETH_ST_PULSE &&
    pulse_end;
  wire logic arm_ret = arm_byp && arm_src == ETH_SRC_EXT && st_r == ETH_ST_PULSE &&
    pulse_end && !scan_more;

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ETH_ST_IDLE: if (cont_on || init_r) st_nxt = ETH_ST_ARM;
      ETH_ST_ARM: if (arm_go) st_nxt = ETH_ST_SCAN;
      ETH_ST_SCAN: if (scan_go) st_nxt = ETH_ST_MEAS;
      ETH_ST_MEAS: if (meas_go) st_nxt = ETH_ST_SETTLE;
      ETH_ST_SETTLE: if (wait_end) st_nxt = ETH_ST_PULSE;
      ETH_ST_PULSE: begin
        if (pulse_end) begin
          if (scan_more) st_nxt = ETH_ST_SCAN;
          else if (arm_more) st_nxt = ETH_ST_ARM;
          else st_nxt = ETH_ST_IDLE;
        end
      end
      default: st_nxt = ETH_ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ETH_ST_IDLE;
      wait_r <= 17'h0_0000;
      tick_r <= 16'h0000;
      arm_first_r <= 1'b1;
      scan_first_r <= 1'b1;
      arm_done_r <= 17'h0_0000;
      scan_done_r <= 17'h0_0000;
      ret_pulse_r <= 1'b0;
      done_n_r <= 1'b1;
      meas_r <= 1'b0;
      store_r <= 1'b0;
      readings_r <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
      tick_r <= tick ? 16'h0000 : 16'(tick_r + 16'h0001);
      wait_r <= (st_nxt != st_r) ? 17'h0_0000 : 17'(wait_r + 17'h0_0001);
      meas_r <= st_r == ETH_ST_MEAS && meas_go;
      store_r <= meas_r && ctrl_r[ETH_F_STORE];
      if (store_r) readings_r <= 32'(readings_r + 32'h0000_0001);
      if (st_r == ETH_ST_ARM && arm_go) arm_first_r <= 1'b0;
      if (st_r == ETH_ST_SCAN && scan_go) scan_first_r <= 1'b0;
      if (st_r == ETH_ST_PULSE && pulse_end) begin
        scan_done_r <= scan_more ? 17'(scan_done_r + 17'h0_0001) : 17'h0_0000;
        if (!scan_more) arm_done_r <= arm_more ? 17'(arm_done_r + 17'h0_0001) : 17'h0_0000;
      end
      if (st_r == ETH_ST_IDLE) begin
        arm_first_r <= 1'b1;
        scan_first_r <= 1'b1;
      end
      ret_pulse_r <= scan_ret || arm_ret;
      done_n_r <= !(st_nxt == ETH_ST_PULSE || ret_pulse_r);
    end
  end
  assign done_out_n = done_n_r;
  assign meas_start = meas_r;
  assign store_strobe = store_r;

  // axi4-lite slave
  logic aw_r;
  logic w_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r;
  logic bv_r;
  logic rv_r;
  logic [31:0] rd_r;
  logic [1:0] rr_r;
  logic [1:0] br_r;
  wire logic do_wr = aw_r && w_r && !bv_r;
  wire logic do_rd = s_axi_arvalid && !rv_r;
  wire logic [7:0] ra = s_axi_araddr[7:0];
  wire logic wr_ctrl = do_wr && awa_r == ETH_OFF_CTRL;
  wire logic wr_arm = do_wr && awa_r == ETH_OFF_ARM_CNT && wd_r[16:0] <= ETH_CNT_MAX;
  wire logic wr_scan = do_wr && awa_r == ETH_OFF_SCAN_CNT && wd_r[16:0] <= ETH_CNT_MAX;
  wire logic wr_tim = do_wr && awa_r == ETH_OFF_TIMING;
  wire logic wr_cmd = do_wr && awa_r == ETH_OFF_CMD;
  wire logic wr_ok = wr_ctrl || wr_arm || wr_scan || wr_tim || wr_cmd;
  wire logic [31:0] rdata = (ra == ETH_OFF_CTRL) ? {16'h0000, ctrl_r} :
    (ra == ETH_OFF_ARM_CNT) ? {15'h0000, arm_cnt_r} :
    (ra == ETH_OFF_SCAN_CNT) ? {15'h0000, scan_cnt_r} :
    (ra == ETH_OFF_TIMING) ? {delay_r, settle_r} :
    (ra == ETH_OFF_STATUS) ? {readings_r[23:0], 3'h0, trig.level, done_n_r, st_r} :
    32'h0000_0000;
  wire logic rd_ok = ra == ETH_OFF_CTRL || ra == ETH_OFF_ARM_CNT || ra == ETH_OFF_SCAN_CNT ||
    ra == ETH_OFF_TIMING || ra == ETH_OFF_STATUS || ra == ETH_OFF_CMD;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awa_r <= 8'h00;
      wd_r <= 32'h0000_0000;
      bv_r <= 1'b0;
      br_r <= 2'b00;
      rv_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rr_r <= 2'b00;
      ctrl_r <= ETH_RST_CTRL;
      arm_cnt_r <= ETH_RST_ARM_CNT;
      scan_cnt_r <= ETH_RST_SCAN_CNT;
      settle_r <= ETH_RST_SETTLE;
      delay_r <= ETH_RST_DELAY;
      pulse_r <= ETH_RST_PULSE;
      timer_r <= ETH_RST_TIMER;
      manual_r <= 1'b0;
      init_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_r) begin
        aw_r <= 1'b1;
        awa_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_r) begin
        w_r <= 1'b1;
        wd_r <= s_axi_wdata;
      end
      manual_r <= wr_cmd && wd_r[ETH_F_MANUAL];
      init_r <= wr_cmd && wd_r[ETH_F_INIT];
      if (do_wr) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        bv_r <= 1'b1;
        br_r <= wr_ok ? 2'b00 : 2'b10;
      end else if (bv_r && s_axi_bready) begin
        bv_r <= 1'b0;
      end
      if (wr_ctrl) ctrl_r <= wd_r[15:0];
      if (wr_arm) arm_cnt_r <= wd_r[16:0];
      if (wr_scan) scan_cnt_r <= wd_r[16:0];
      if (wr_tim) begin
        settle_r <= wd_r[15:0];
        delay_r <= wd_r[31:16];
      end
      if (wr_cmd && wd_r[15:8] != 8'h00) pulse_r <= wd_r[15:8];
      if (wr_cmd && wd_r[31:16] != 16'h0000) timer_r <= wd_r[31:16];
      if (do_rd) begin
        rv_r <= 1'b1;
        rd_r <= rdata;
        rr_r <= rd_ok ? 2'b00 : 2'b10;
      end else if (rv_r && s_axi_rready) begin
        rv_r <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_r;
  assign s_axi_wready = !w_r;
  assign s_axi_bvalid = bv_r;
  assign s_axi_bresp = br_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid = rv_r;
  assign s_axi_rdata = rd_r;
  assign s_axi_rresp = rr_r;

  sequence seq_meas_taken;
    meas_r ##1 store_r;
  endsequence
  chk_store_then_done: assert property (@(posedge aclk) disable iff (!aresetn)
    seq_meas_taken |-> done_n_r)
    else $error("completion before store");
  chk_fall_only_ext: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ETH_ST_MEAS && meas_src == ETH_SRC_EXT && !trig.fall && !manual_r)
    |=> st_r == ETH_ST_MEAS)
    else $error("external measure advanced without trigger");
  chk_settle_before_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_r == ETH_ST_PULSE) |-> $past(wait_end))
    else $error("completion before settling");
  chk_pulse_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ETH_ST_SETTLE && wait_end) |=> !done_n_r)
    else $error("completion pulse missing");
  chk_hold_no_scan: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ETH_ST_ARM && arm_src == ETH_SRC_HOLD) |=> st_r != ETH_ST_SCAN)
    else $error("hold arm source advanced");
  chk_imm_drop: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ETH_ST_ARM && arm_src == ETH_SRC_IMM && scan_src == ETH_SRC_IMM)
    |=> ##1 st_r == ETH_ST_MEAS)
    else $error("immediate layers did not drop to measure");
  chk_scan_return: assert property (@(posedge aclk) disable iff (!aresetn)
    scan_ret |=> ##1 !done_n_r)
    else $error("scan return pulse missing");
  chk_arm_return: assert property (@(posedge aclk) disable iff (!aresetn)
    arm_ret |=> ##1 !done_n_r)
    else $error("arm return pulse missing");
  chk_bypass_once: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_r == ETH_ST_SCAN && !scan_first_r && scan_src == ETH_SRC_EXT && !trig.fall && !manual_r)
    |=> st_r == ETH_ST_SCAN)
    else $error("bypass used on later pass");
endmodule
`default_nettype wire

// file: design/eth_pkg.sv
// package of constants and types for the trigger handshake block
package eth_pkg;
  localparam int unsigned ETH_CLK_HZ = 20000000;
  localparam int unsigned ETH_CLK_NS = 50;
  localparam int unsigned ETH_MIN_PULSE_NS = 2000;
  localparam int unsigned ETH_MIN_PULSE_CYC = (ETH_MIN_PULSE_NS + ETH_CLK_NS - 1) / ETH_CLK_NS;
  // register offsets
  localparam logic [7:0] ETH_OFF_CTRL = 8'h00;
  localparam logic [7:0] ETH_OFF_ARM_CNT = 8'h04;
  localparam logic [7:0] ETH_OFF_SCAN_CNT = 8'h08;
  localparam logic [7:0] ETH_OFF_TIMING = 8'h0c;
  localparam logic [7:0] ETH_OFF_STATUS = 8'h10;
  localparam logic [7:0] ETH_OFF_CMD = 8'h14;
  // ctrl field positions
  localparam int unsigned ETH_F_ARM_SRC = 0;
  localparam int unsigned ETH_F_SCAN_SRC = 4;
  localparam int unsigned ETH_F_MEAS_SRC = 8;
  localparam int unsigned ETH_F_ARM_BYP = 12;
  localparam int unsigned ETH_F_SCAN_BYP = 13;
  localparam int unsigned ETH_F_CONT = 14;
  localparam int unsigned ETH_F_STORE = 15;
  // cmd bits
  localparam int unsigned ETH_F_MANUAL = 0;
  localparam int unsigned ETH_F_INIT = 1;
  // count 0 means infinite
  localparam logic [16:0] ETH_CNT_INF = 17'h0_0000;
  localparam logic [16:0] ETH_CNT_MAX = 17'h1_869f;
  localparam logic [16:0] ETH_RST_ARM_CNT = 17'h0_0001;
  localparam logic [16:0] ETH_RST_SCAN_CNT = 17'h0_0000;
  // continuous on, all sources immediate, no bypass
  localparam logic [15:0] ETH_RST_CTRL = 16'h4000;
  localparam logic [15:0] ETH_RST_SETTLE = 16'h0010;
  localparam logic [15:0] ETH_RST_DELAY = 16'h0000;
  localparam logic [7:0] ETH_RST_PULSE = 8'h28;
  localparam logic [15:0] ETH_RST_TIMER = 16'h0100;
  typedef enum logic [2:0] {
    ETH_SRC_IMM = 3'b000,
    ETH_SRC_EXT = 3'b001,
    ETH_SRC_MAN = 3'b010,
    ETH_SRC_TIM = 3'b011,
    ETH_SRC_HOLD = 3'b100
  } eth_src_t;
  typedef enum logic [2:0] {
    ETH_ST_IDLE = 3'b000,
    ETH_ST_ARM = 3'b001,
    ETH_ST_SCAN = 3'b010,
    ETH_ST_MEAS = 3'b011,
    ETH_ST_SETTLE = 3'b100,
    ETH_ST_PULSE = 3'b101
  } eth_state_t;
endpackage

// file: design/eth_trig_if.sv
// interface carrying the trigger input filter result
`timescale 1ns/10ps
`default_nettype none
interface eth_trig_if;
  logic fall;
  logic level;
  modport src (output fall, output level);
  modport dst (input fall, input level);
endinterface
`default_nettype wire

// file: design/eth_trig_filter.sv
// trigger input synchroniser, glitch filter and falling edge detector
`timescale 1ns/10ps
`default_nettype none
module eth_trig_filter
  import eth_pkg::*;
#(
  parameter int unsigned MIN_CYC = ETH_MIN_PULSE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic trig_in_n,
  eth_trig_if.src out
);
  logic s1_r;
  logic s2_r;
  logic filt_r;
  logic fall_r;
  logic [7:0] cnt_r;
  wire logic differs = s2_r != filt_r;
  wire logic stable = cnt_r >= 8'(MIN_CYC - 1);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      filt_r <= 1'b1;
      fall_r <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      s1_r <= trig_in_n;
      s2_r <= s1_r;
      cnt_r <= differs ? 8'(cnt_r + 8'h01) : 8'h00;
      if (differs && stable) begin
        filt_r <= s2_r;
        cnt_r <= 8'h00;
      end
      fall_r <= differs && stable && !s2_r;
    end
  end
  assign out.fall = fall_r;
  assign out.level = filt_r;
  chk_short_low_rejected: assert property (@(posedge aclk) disable iff (!aresetn)
    out.fall |-> $past(!s2_r, 1) && $past(!s2_r, 2))
    else $error("trigger accepted after short low pulse");
endmodule
`default_nettype wire

// file: bench/eth_scanner_model.sv
// scanner model that answers completion pulses with channel ready triggers
`timescale 1ns/10ps
`default_nettype none
module eth_scanner_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic done_out_n,
  input wire logic fire,
  input wire logic auto_step,
  input wire logic [7:0] low_len,
  output logic trig_in_n
);
  logic done_q;
  int cnt;
  // line idles high, low pulse after a completion pulse has ended
  always @(posedge aclk) begin
    done_q <= done_out_n;
    if (!aresetn) begin
      trig_in_n <= 1'b1;
      done_q <= 1'b1;
      cnt <= 0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      trig_in_n <= (cnt == 1);
    end else if (fire || (auto_step && !done_q && done_out_n)) begin
      cnt <= low_len;
      trig_in_n <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: bench/test_ext_trigger_handshake.sv
// self-checking bench for the trigger handshake block
`timescale 1ns/10ps
`default_nettype none
module test_ext_trigger_handshake;
  import eth_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [1:0] resp;
  } eth_row_t;
  logic aclk, aresetn, trig_in_n, done_out_n, meas_start, store_strobe, fire, auto_step;
  logic [31:0] awaddr, wdata, araddr, rdata, d;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, r;
  logic [7:0] low_len;
  int bad_count, cmp_count, cyc, meas_cnt, long_cnt, short_cnt, low_run, t_meas, t_store;
  int t_done, last_w;
  eth_row_t rows [10];
  eth_trigger_handshake i_dut (.aclk(aclk), .aresetn(aresetn), .trig_in_n(trig_in_n),
    .done_out_n(done_out_n), .meas_start(meas_start), .store_strobe(store_strobe),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  eth_scanner_model i_scan (.aclk(aclk), .aresetn(aresetn), .done_out_n(done_out_n),
    .fire(fire), .auto_step(auto_step), .low_len(low_len), .trig_in_n(trig_in_n));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // pulse monitor and timeout
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (meas_start === 1'b1) begin
      meas_cnt <= meas_cnt + 1;
      t_meas <= cyc;
    end
    if (store_strobe === 1'b1) t_store <= cyc;
    if (done_out_n === 1'b0) begin
      if (low_run == 0) t_done <= cyc;
      low_run <= low_run + 1;
    end else if (low_run != 0) begin
      low_run <= 0;
      last_w <= low_run;
      if (low_run == 1) short_cnt <= short_cnt + 1;
      else long_cnt <= long_cnt + 1;
    end
    if (cyc == 60000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic dn;
    dn = 1'b0;
    @(posedge aclk);
    awaddr <= {24'h00_0000, a};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        rs = bresp;
        dn = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic dn;
    dn = 1'b0;
    @(posedge aclk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        v = rdata;
        rs = rresp;
        dn = 1'b1;
      end
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wait_long(input int k);
    for (int n = 0; n < 4000 && long_cnt < k; n++) @(posedge aclk);
  endtask
  task automatic clr();
    @(negedge aclk);
    meas_cnt = 0;
    long_cnt = 0;
    short_cnt = 0;
  endtask
  task automatic kick(input logic [7:0] n);
    @(posedge aclk);
    low_len <= n;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    {fire, auto_step, low_len} = '0;
    rows[0] = '{1'b0, ETH_OFF_CTRL, 32'h0000_4000, 2'b00};
    rows[1] = '{1'b0, ETH_OFF_ARM_CNT, 32'h0000_0001, 2'b00};
    rows[2] = '{1'b0, ETH_OFF_SCAN_CNT, 32'h0000_0000, 2'b00};
    rows[3] = '{1'b0, ETH_OFF_TIMING, 32'h0000_0010, 2'b00};
    rows[4] = '{1'b0, 8'h18, 32'h0000_0000, 2'b10};
    rows[5] = '{1'b1, ETH_OFF_STATUS, 32'h0000_0000, 2'b10};
    rows[6] = '{1'b1, ETH_OFF_ARM_CNT, 32'h0001_869f, 2'b00};
    rows[7] = '{1'b1, ETH_OFF_ARM_CNT, 32'h0001_86a0, 2'b10};
    rows[8] = '{1'b0, ETH_OFF_ARM_CNT, 32'h0001_869f, 2'b00};
    rows[9] = '{1'b1, ETH_OFF_ARM_CNT, 32'h0000_0001, 2'b00};
    do_reset();
    chk("idle level", 32'h1, {31'h0, done_out_n});
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].data, r);
      end else begin
        rd(rows[i].addr, d, r);
        chk("rdata", rows[i].data, d);
      end
      chk("resp", {30'h0, rows[i].resp}, {30'h0, r});
    end
    $display("register test done");
    wr(ETH_OFF_CTRL, 32'h0000_c100, r);
    wr(ETH_OFF_TIMING, 32'h0004_0010, r);
    idle(200);
    clr();
    kick(8'hc8);
    wait_long(1);
    chk("latency", 32'd21, t_done - t_meas);
    chk("store", t_meas + 1, t_store);
    chk("width", 32'd40, last_w);
    idle(300);
    chk("one reading", 32'd1, meas_cnt);
    clr();
    kick(8'h0a);
    idle(300);
    chk("glitch", 32'd0, meas_cnt);
    $display("external trigger test done");
    wr(ETH_OFF_CTRL, 32'h0000_4200, r);
    idle(200);
    clr();
    kick(8'hc8);
    idle(400);
    chk("ignored", 32'd0, meas_cnt);
    wr(ETH_OFF_CMD, 32'h0000_0001, r);
    wait_long(1);
    chk("manual", 32'd1, meas_cnt);
    for (int s = 0; s < 4; s += 3) begin
      wr(ETH_OFF_CTRL, 32'h0000_4000 | (s << 8), r);
      clr();
      wait_long(2);
      chk("free run", 32'd2, long_cnt);
    end
    $display("source test done");
    do_reset();
    wr(ETH_OFF_CTRL, 32'h0000_4100, r);
    idle(200);
    clr();
    auto_step <= 1'b1;
    kick(8'h3c);
    wait_long(3);
    chk("chain", 32'd3, meas_cnt);
    auto_step <= 1'b0;
    do_reset();
    wr(ETH_OFF_SCAN_CNT, 32'h0000_0001, r);
    wr(ETH_OFF_CTRL, 32'h0000_4004, r);
    idle(1000);
    clr();
    idle(500);
    chk("hold", 32'd0, meas_cnt);
    wr(ETH_OFF_CTRL, 32'h0000_4000, r);
    wait_long(1);
    chk("release", 32'd1, long_cnt);
    wr(ETH_OFF_CTRL, 32'h0000_0000, r);
    idle(300);
    clr();
    idle(300);
    chk("no restart", 32'd0, meas_cnt);
    wr(ETH_OFF_CMD, 32'h0000_0002, r);
    wait_long(1);
    idle(300);
    chk("initiate", 32'd1, meas_cnt);
    $display("scanner and hold test done");
    for (int k = 0; k < 2; k++) begin
      do_reset();
      wr(ETH_OFF_ARM_CNT, 32'h0000_0002, r);
      wr(ETH_OFF_SCAN_CNT, 32'h0000_0002 - k, r);
      clr();
      wr(ETH_OFF_CTRL, k ? 32'h0000_5001 : 32'h0000_6010, r);
      for (int n = 0; n < 4000 && short_cnt == 0; n++) @(posedge aclk);
      chk("return pulse", 32'd1, short_cnt);
      idle(300);
      clr();
      idle(500);
      chk("waits event", 32'd0, meas_cnt);
      kick(8'h3c);
      wait_long(1);
      chk("event", 32'd1, long_cnt);
    end
    $display("bypass test done");
    final_report();
  end
endmodule
`default_nettype wire
